// ### logic/sfc_top.sv
// Contract
// R1 - Control bit 2 set inverts second-channel receive pin before use.
// R2 - Control bit 1 set inverts data driven on first-channel transmit pin.
// R3 - Control bit 0 set inverts first-channel receive pin before sampling.
// R4 - Mode bit 7 clear selects asynchronous, set selects synchronous.
// R5 - Asynchronous characters carry five, seven or eight data bits.
// R6 - Optional parity or multiprocessor bit, then one or two stop bits.
// R7 - Format fields decode length; both parity and multiprocessor force five bits.
// R8 - Mode bit 3 clear sends one stop bit, set sends two.
// R9 - Asynchronous receive reports framing, parity, overrun and break.
// R10 - Internal clock times bits; bit-rate clock may go to clock pin.
// R11 - External asynchronous clock must run at sixteen times bit rate.
// R12 - Synchronous mode is always eight bits, no parity, no stop.
// R13 - Synchronous receive detects only overrun.
// R14 - Synchronous clock is driven out internally, else taken from pin.
// R15 - Clock source decoded from sync select and two clock-enable bits.
// R16 - Software never programs clock-source codes 011, 101 or 111.
// R17 - Receiver syncs on start falling edge, samples eighth of sixteen.
// R18 - Low start, data LSB first, optional bit, high stops; idles high.
// R19 - Inversion sits between pin and shift logic.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "sfc_params.svh"
module sfc_top (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_pin_ch1,
   input  wire logic        rx_pin_ch2,
   output logic             tx_pin_ch1,
   input  wire logic        serial_clock_pin_in,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe
);
   import sfc_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a <= `SFC_STAT_OFS) && (a[1:0] == 2'b00);
   endfunction

   function automatic sfc_frame_s frame_decode(input logic [7:0] f);
      sfc_frame_s d;
      d = '0;
      d.dlen = f[`SFC_FMT_LEN7] ? `SFC_DLEN7 : `SFC_DLEN8; // [R5]
      if (f[`SFC_FMT_SYNC]) begin
         d.dlen = `SFC_DLEN8; // [R12]
      end else begin
         d.stop2 = f[`SFC_FMT_STOP]; // [R8]
         case ({f[`SFC_FMT_MPS], f[`SFC_FMT_PAR]}) // [R7] [R6]
            2'b01: begin
               d.extra = 1'b1;
               d.par   = 1'b1;
            end
            2'b10: d.extra = 1'b1;
            2'b11: begin
               d.dlen  = `SFC_DLEN5;
               d.extra = f[`SFC_FMT_LEN7];
               d.par   = f[`SFC_FMT_LEN7];
            end
            default: d.extra = 1'b0;
         endcase
      end
      frame_decode = d;
   endfunction

   // ----------------------------------------------------------------
   // Registers and pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0] fmt, ctrl, pin, div, stat;
   logic [7:0] next_fmt, next_ctrl, next_pin, next_div;
   logic [7:0] rx_data, next_rx_data;
   logic [5:0] flags, next_flags;
   logic [2:0] s1, s2, s3;
   logic [31:0] next_prdata;
   logic       wr_en, rd_done, sync_md, rx_line, buf_in_ready;
   logic [2:0] cksel;
   sfc_frame_s fr;

   assign sync_md = fmt[`SFC_FMT_SYNC]; // [R4]
   assign cksel   = {sync_md, ctrl[`SFC_CTRL_CKH], ctrl[`SFC_CTRL_CKL]};
   assign fr      = frame_decode(fmt);
   // Post-inversion receive level, seen by all receive logic
   assign rx_line = ctrl[`SFC_CTRL_RSEL]
                  ? (s2[1] ^ pin[`SFC_PIN_RX2])  // [R1] [R19]
                  : (s2[0] ^ pin[`SFC_PIN_RX1]); // [R3] [R19]

   // Bus handshake; a full transmit buffer stretches the access
   always_comb begin
      pready  = clk_en & ~(paddr == `SFC_TXD_OFS && pwrite && !buf_in_ready);
      pslverr = psel & penable & ~addr_ok(paddr);
      wr_en   = psel & penable & pwrite & pready & addr_ok(paddr);
      rd_done = psel & penable & ~pwrite & pready & addr_ok(paddr);
   end

   // Software register next values
   always_comb begin
      next_fmt  = fmt;
      next_ctrl = ctrl;
      next_pin  = pin;
      next_div  = div;
      if (wr_en) begin
         case (paddr)
            `SFC_FMT_OFS:  next_fmt  = pwdata[7:0];
            `SFC_CTRL_OFS: next_ctrl = pwdata[7:0];
            `SFC_PIN_OFS:  next_pin  = pwdata[7:0] | `SFC_PIN_RO;
            `SFC_DIV_OFS:  next_div  = pwdata[7:0];
            default:       next_fmt  = fmt;
         endcase
      end
      stat = {2'b00, flags};
      case (paddr)
         `SFC_FMT_OFS:  next_prdata = {24'h0, fmt};
         `SFC_CTRL_OFS: next_prdata = {24'h0, ctrl};
         `SFC_PIN_OFS:  next_prdata = {24'h0, pin};
         `SFC_DIV_OFS:  next_prdata = {24'h0, div};
         `SFC_RXD_OFS:  next_prdata = {24'h0, rx_data};
         `SFC_STAT_OFS: next_prdata = {24'h0, stat};
         default:       next_prdata = 32'h0;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fmt    <= `SFC_FMT_RST;
         ctrl   <= `SFC_CTRL_RST;
         pin    <= `SFC_PIN_RST;
         div    <= `SFC_DIV_RST;
         prdata <= 32'h0;
         s1     <= 3'h7;
         s2     <= 3'h7;
         s3     <= 3'h7;
      end else if (clk_en) begin
         fmt    <= next_fmt;
         ctrl   <= next_ctrl;
         pin    <= next_pin;
         div    <= next_div;
         if (psel && !penable) begin
            prdata <= next_prdata;
         end
         s1     <= {serial_clock_pin_in, rx_pin_ch2, rx_pin_ch1};
         s2     <= s1;
         s3     <= s2;
      end
   end

   // ----------------------------------------------------------------
   // Clock source and bit timing
   // ----------------------------------------------------------------
   logic [7:0] div_cnt, next_div_cnt;
   logic [3:0] os_ph, next_os_ph;
   logic       os_tick, ext_rise, ext_fall, sck_rise, sck_fall;
   logic       gen_sck, next_gen_sck, cm_ext, tx_busy;

   assign ext_rise = s2[2] & ~s3[2];
   assign ext_fall = ~s2[2] & s3[2];
   assign cm_ext   = ctrl[`SFC_CTRL_CKH];
   // External async clock is the 16x clock, generator bypassed
   assign os_tick  = (cksel == 3'b010) ? ext_rise  // [R11]
                                        : (div_cnt == 8'h00); // [R10]
   assign sck_rise = cm_ext ? ext_rise : (os_tick & ~gen_sck & tx_busy);
   assign sck_fall = cm_ext ? ext_fall : (os_tick & gen_sck); // [R14]

   always_comb begin
      next_div_cnt = (div_cnt == 8'h00) ? div : div_cnt - 8'h01;
      next_os_ph   = os_tick ? os_ph + 4'h1 : os_ph;
      next_gen_sck = gen_sck;
      if (sync_md && os_tick && (tx_busy || gen_sck)) begin
         next_gen_sck = ~gen_sck;
      end
   end

   // Clock pin drive; reserved codes leave the pin undriven
   always_comb begin
      case (cksel) // [R15] [R16]
         3'b001: begin
            serial_clock_pin_oe  = 1'b1;
            serial_clock_pin_out = os_ph[3]; // [R10]
         end
         3'b100: begin
            serial_clock_pin_oe  = 1'b1;
            serial_clock_pin_out = gen_sck; // [R14]
         end
         default: begin
            serial_clock_pin_oe  = 1'b0;
            serial_clock_pin_out = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 8'h00;
         os_ph   <= 4'h0;
         gen_sck <= 1'b0;
      end else if (clk_en) begin
         div_cnt <= next_div_cnt;
         os_ph   <= next_os_ph;
         gen_sck <= next_gen_sck;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   sfc_tx_state_e tx_st, next_tx_st;
   logic [11:0] tx_sh, next_tx_sh, mask, dm;
   logic [3:0]  tx_left, next_tx_left, sh_ext, sh_stop;
   logic [7:0]  bq_data;
   logic        bq_valid, bq_ready, ext_bit, next_txp, tx_step;

   sfc_buf #(.WIDTH(8), .DEPTH(2)) u_txbuf (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_data   (pwdata[7:0]),
      .in_valid  (wr_en && paddr == `SFC_TXD_OFS),
      .in_ready  (buf_in_ready),
      .out_data  (bq_data),
      .out_valid (bq_valid),
      .out_ready (bq_ready)
   );

   assign tx_busy = (tx_st == SFC_TX_SHIFT);
   assign tx_step = sync_md ? sck_fall
                            : (os_tick && os_ph == `SFC_OS_LAST);

   // Frame build, shift and load
   always_comb begin
      mask    = ~(12'hfff << fr.dlen);
      dm      = {4'h0, bq_data} & mask;
      ext_bit = fr.par ? (^dm ^ fmt[`SFC_FMT_ODD]) : ctrl[`SFC_CTRL_MPB];
      sh_ext  = fr.dlen + 4'h1;
      sh_stop = sh_ext + {3'b000, fr.extra};
      bq_ready     = 1'b0;
      next_tx_st   = tx_st;
      next_tx_sh   = tx_sh;
      next_tx_left = tx_left;
      case (tx_st)
         SFC_TX_IDLE: begin
            if (bq_valid && ctrl[`SFC_CTRL_TE] && (sync_md || tx_step)) begin
               bq_ready   = 1'b1;
               next_tx_st = SFC_TX_SHIFT;
               if (sync_md) begin
                  next_tx_sh   = {4'hf, bq_data}; // [R12]
                  next_tx_left = `SFC_DLEN8;
               end else begin
                  next_tx_sh = (12'hfff << sh_stop) | (dm << 1)
                             | ({11'h0, ext_bit & fr.extra} << sh_ext); // [R18]
                  next_tx_left = sh_stop + 4'h1 + {3'b000, fr.stop2}; // [R8]
               end
            end
         end
         SFC_TX_SHIFT: begin
            if (!ctrl[`SFC_CTRL_TE]) begin
               next_tx_st = SFC_TX_IDLE;
            end else if (tx_step) begin
               next_tx_sh   = {1'b1, tx_sh[11:1]};
               next_tx_left = tx_left - 4'h1;
               if (tx_left == 4'h1) begin
                  next_tx_st = SFC_TX_IDLE;
               end
            end
         end
         default: next_tx_st = SFC_TX_IDLE;
      endcase
      next_txp = (tx_busy ? tx_sh[0] : 1'b1) ^ pin[`SFC_PIN_TX1]; // [R2]
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_st      <= SFC_TX_IDLE;
         tx_sh      <= 12'hfff;
         tx_left    <= 4'h0;
         tx_pin_ch1 <= 1'b1;
      end else if (clk_en) begin
         tx_st      <= next_tx_st;
         tx_sh      <= next_tx_sh;
         tx_left    <= next_tx_left;
         tx_pin_ch1 <= next_txp;
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   sfc_rx_state_e rx_st, next_rx_st;
   logic [11:0] rx_sh, next_rx_sh, word;
   logic [3:0]  rx_cnt, next_rx_cnt, rx_bits, next_rx_bits, nb;
   logic        rx_done, rx_take, rx_ext, rx_stop, rd_rxd;

   assign nb     = sync_md ? `SFC_DLEN8
                           : fr.dlen + 4'h1 + {3'b000, fr.extra};
   assign word   = next_rx_sh >> (`SFC_WORD - nb);
   assign rx_ext = word[fr.dlen];
   assign rx_stop = word[sh_ext - 4'h1 + {3'b000, fr.extra}];
   assign rd_rxd = rd_done && paddr == `SFC_RXD_OFS;

   always_comb begin
      next_rx_st   = rx_st;
      next_rx_sh   = rx_sh;
      next_rx_cnt  = rx_cnt;
      next_rx_bits = rx_bits;
      rx_take      = 1'b0;
      case (rx_st)
         SFC_RX_IDLE: begin
            next_rx_bits = sync_md ? rx_bits : 4'h0;
            if (ctrl[`SFC_CTRL_RE] && sync_md && sck_rise) begin
               rx_take = 1'b1;
            end else if (ctrl[`SFC_CTRL_RE] && !sync_md && !rx_line) begin
               next_rx_st  = SFC_RX_START; // [R17]
               next_rx_cnt = 4'h0;
            end
         end
         SFC_RX_START: begin
            if (os_tick) begin
               next_rx_cnt = rx_cnt + 4'h1;
               if (rx_cnt == `SFC_OS_MID) begin // [R17]
                  next_rx_st  = rx_line ? SFC_RX_IDLE : SFC_RX_DATA;
                  next_rx_cnt = 4'h0;
               end
            end
         end
         SFC_RX_DATA: begin
            if (os_tick) begin
               next_rx_cnt = rx_cnt + 4'h1;
               rx_take     = (rx_cnt == `SFC_OS_LAST);
            end
         end
         default: next_rx_st = SFC_RX_IDLE;
      endcase
      if (rx_take) begin
         next_rx_sh   = {rx_line, rx_sh[11:1]}; // [R18]
         next_rx_bits = rx_bits + 4'h1;
      end
      rx_done = rx_take && (rx_bits + 4'h1 == nb);
      if (rx_done) begin
         next_rx_bits = 4'h0;
         next_rx_st   = SFC_RX_IDLE;
      end
      if (!ctrl[`SFC_CTRL_RE]) begin
         next_rx_st = SFC_RX_IDLE;
      end
   end

   // Received data and sticky flags; a new event wins over a clear
   always_comb begin
      next_flags   = flags;
      next_rx_data = rx_data;
      if (wr_en && paddr == `SFC_STAT_OFS) begin
         next_flags = flags & ~{1'b0, pwdata[4:1], 1'b0};
      end
      if (rd_rxd) begin
         next_flags[`SFC_ST_FULL] = 1'b0;
      end
      next_flags[`SFC_ST_TXE] = ~bq_valid & ~tx_busy;
      if (rx_done) begin
         if (flags[`SFC_ST_FULL] && !rd_rxd) begin
            next_flags[`SFC_ST_OVR] = 1'b1; // [R9] [R13]
         end else begin
            next_rx_data = word[7:0] & mask[7:0];
            next_flags[`SFC_ST_FULL] = 1'b1;
         end
         if (!sync_md) begin
            if (!rx_stop) begin
               next_flags[`SFC_ST_FRM] = 1'b1; // [R9]
            end
            if (fr.par && (rx_ext != (^(word & mask)
                                    ^ fmt[`SFC_FMT_ODD]))) begin
               next_flags[`SFC_ST_PAR] = 1'b1; // [R9]
            end
            if (word == 12'h000) begin
               next_flags[`SFC_ST_BRK] = 1'b1; // [R9]
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_st   <= SFC_RX_IDLE;
         rx_sh   <= 12'h000;
         rx_cnt  <= 4'h0;
         rx_bits <= 4'h0;
         rx_data <= 8'h00;
         flags   <= 6'h20;
      end else if (clk_en) begin
         rx_st   <= next_rx_st;
         rx_sh   <= next_rx_sh;
         rx_cnt  <= next_rx_cnt;
         rx_bits <= next_rx_bits;
         rx_data <= next_rx_data;
         flags   <= next_flags;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   rx1_invert_a: assert property (!ctrl[`SFC_CTRL_RSEL] |-> // [R3]
      rx_line == (s2[0] ^ pin[`SFC_PIN_RX1]))
      else $error("channel one receive inversion wrong");
   rx2_invert_a: assert property (ctrl[`SFC_CTRL_RSEL] |-> // [R1]
      rx_line == (s2[1] ^ pin[`SFC_PIN_RX2]))
      else $error("channel two receive inversion wrong");
   tx1_invert_a: assert property (clk_en |=> // [R2]
      tx_pin_ch1 == (($past(tx_busy) ? $past(tx_sh[0]) : 1'b1)
                     ^ $past(pin[`SFC_PIN_TX1])))
      else $error("transmit pin inversion wrong");
   sync_len_a: assert property (clk_en && bq_ready && sync_md |=> // [R12]
      tx_left == `SFC_DLEN8 && tx_sh[11:8] == 4'hf)
      else $error("synchronous frame not eight bits");
   async_frame_a: assert property (clk_en && bq_ready && !sync_md |=> // [R18]
      tx_sh[0] == 1'b0 && tx_sh[11] == 1'b1)
      else $error("asynchronous frame lacks start or stop");
   stop_count_a: assert property (clk_en && bq_ready && !sync_md |=> // [R8]
      tx_left == $past(sh_stop) + 4'h1 + {3'b000, $past(fmt[3])})
      else $error("stop bit count wrong");
   five_bit_a: assert property (!sync_md && fmt[`SFC_FMT_PAR] // [R7]
      && fmt[`SFC_FMT_MPS] |-> fr.dlen == `SFC_DLEN5
      && fr.par == fmt[`SFC_FMT_LEN7])
      else $error("five bit format decode wrong");
   start_check_a: assert property (clk_en && rx_st == SFC_RX_START // [R17]
      && os_tick && rx_cnt == `SFC_OS_MID && rx_line
      && ctrl[`SFC_CTRL_RE] |=> rx_st == SFC_RX_IDLE)
      else $error("false start not rejected at mid bit");
   overrun_a: assert property (clk_en && rx_done // [R9]
      && flags[`SFC_ST_FULL] && !rd_rxd |=> flags[`SFC_ST_OVR])
      else $error("overrun not flagged");
   sync_errs_a: assert property (clk_en && rx_done && sync_md // [R13]
      && !flags[`SFC_ST_FRM] |=> !flags[`SFC_ST_FRM])
      else $error("framing flagged in synchronous mode");
   clk_pin_a: assert property (serial_clock_pin_oe |-> // [R15]
      (cksel == 3'b001 || cksel == 3'b100))
      else $error("clock pin driven in wrong mode");
   ext_tick_a: assert property (cksel == 3'b010 |-> // [R11]
      os_tick == ext_rise)
      else $error("external clock not used as sixteen times clock");

   rx_async_c: cover property (rx_done && !sync_md);
   rx_sync_c: cover property (rx_done && sync_md);
   overrun_c: cover property (rx_done && flags[`SFC_ST_FULL]);
   buf_full_c: cover property (!buf_in_ready && bq_valid);
endmodule

// ### logic/sfc_params.svh
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFC_FMT_OFS   8'h00
`define SFC_CTRL_OFS  8'h04
`define SFC_PIN_OFS   8'h08
`define SFC_DIV_OFS   8'h0c
`define SFC_TXD_OFS   8'h10
`define SFC_RXD_OFS   8'h14
`define SFC_STAT_OFS  8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFC_FMT_SYNC  7
`define SFC_FMT_LEN7  6
`define SFC_FMT_PAR   5
`define SFC_FMT_ODD   4
`define SFC_FMT_STOP  3
`define SFC_FMT_MPS   2
`define SFC_CTRL_MPB  7
`define SFC_CTRL_RSEL 6
`define SFC_CTRL_TE   5
`define SFC_CTRL_RE   4
`define SFC_CTRL_CKH  1
`define SFC_CTRL_CKL  0
`define SFC_PIN_RX2   2
`define SFC_PIN_TX1   1
`define SFC_PIN_RX1   0
`define SFC_ST_FULL   0
`define SFC_ST_OVR    1
`define SFC_ST_FRM    2
`define SFC_ST_PAR    3
`define SFC_ST_BRK    4
`define SFC_ST_TXE    5

// ----------------------------------------------------------------
// Reset values, lengths and timing counts
// ----------------------------------------------------------------
`define SFC_FMT_RST   8'h00
`define SFC_CTRL_RST  8'h00
`define SFC_PIN_RST   8'hc0
`define SFC_PIN_RO    8'hc0
`define SFC_DIV_RST   8'h00
`define SFC_DLEN8     4'h8
`define SFC_DLEN7     4'h7
`define SFC_DLEN5     4'h5
`define SFC_WORD      4'hc
`define SFC_OS_LAST   4'hf
`define SFC_OS_MID    4'h7

`endif

// ### logic/sfc_pkg.sv
package sfc_pkg;
   // One-hot transmitter states
   typedef enum logic [1:0] {
      SFC_TX_IDLE  = 2'b01,
      SFC_TX_SHIFT = 2'b10
   } sfc_tx_state_e;
   // One-hot receiver states
   typedef enum logic [2:0] {
      SFC_RX_IDLE  = 3'b001,
      SFC_RX_START = 3'b010,
      SFC_RX_DATA  = 3'b100
   } sfc_rx_state_e;
   // Decoded character layout
   typedef struct packed {
      logic [3:0] dlen;
      logic       extra;
      logic       par;
      logic       stop2;
   } sfc_frame_s;
endpackage

// ### logic/sfc_buf.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Small valid/ready buffer
// ----------------------------------------------------------------
module sfc_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial begin
      if (DEPTH != 2 || WIDTH < 1) begin
         $error("sfc_buf: depth must be 2, width at least 1");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   // Handshakes and pointer updates
   always_comb begin
      in_ready    = (count != (AW+1)'(DEPTH));
      out_valid   = (count != '0);
      out_data    = mem[rd_ptr];
      push        = in_valid & in_ready;
      pop         = out_valid & out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   // State registers; storage written at the write index
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clk_en) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge mclk) begin
      if (clk_en && push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ### verif/sfc_remote.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote serial device, 16 mclk per bit
// ----------------------------------------
module sfc_remote (
   input  wire logic mclk,
   input  wire logic tx_pin_ch1,
   output logic      rx_pin_ch1,
   output logic      rx_pin_ch2,
   output logic      serial_clock_pin_in
);
   initial begin
      rx_pin_ch1 = 1'b1;
      rx_pin_ch2 = 1'b1;
      serial_clock_pin_in = 1'b0;
   end
   // Idle, start low, data LSB first, stop, idle again
   task automatic send(input logic ch, input logic inv,
                       input logic [7:0] d, input logic stp);
      logic [11:0] fr;
      fr = {2'b11, stp, d, 1'b0};
      for (int i = -32; i < 12 * 16; i++) begin
         @(posedge mclk);
         if (ch) rx_pin_ch2 <= (i < 0 ? 1'b1 : fr[i/16]) ^ inv;
         else rx_pin_ch1 <= (i < 0 ? 1'b1 : fr[i/16]) ^ inv;
      end
   endtask
   // Sixteen-times clock pulses on the clock pin
   task automatic ext16(input int n);
      repeat (n) begin
         @(posedge mclk);
         serial_clock_pin_in <= 1'b1;
         @(posedge mclk);
         serial_clock_pin_in <= 1'b0;
      end
   endtask
   // Start edge, then mid-bit samples
   task automatic grab(input logic inv, output logic [7:0] d);
      int n;
      n = 0;
      d = 8'h00;
      while ((tx_pin_ch1 ^ inv) !== 1'b0 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      repeat (8) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge mclk);
         d[i] = tx_pin_ch1 ^ inv;
      end
   endtask
endmodule

// ### verif/serial_format_clock_select_tb.sv
`timescale 1ns/1ps
`include "sfc_params.svh"
module serial_format_clock_select_tb;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, err, tx1, rx1, rx2, sck_i, sck_o, sck_oe;
   logic [7:0]  got;
   int          num_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #12.5 mclk = ~mclk;
   sfc_top dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_pin_ch1(rx1), .rx_pin_ch2(rx2),
      .tx_pin_ch1(tx1), .serial_clock_pin_in(sck_i),
      .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe));
   sfc_remote u_rem (.mclk(mclk), .tx_pin_ch1(tx1), .rx_pin_ch1(rx1),
      .rx_pin_ch2(rx2), .serial_clock_pin_in(sck_i));
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, then one idle cycle
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
      logic ok;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         ok = pready === 1'b1;
      end while (!ok);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      check(q, exp);
   endtask
   // Reset values, fixed bits, unmapped address
   task automatic t_regs();
      rc(`SFC_FMT_OFS, 32'h00);
      rc(`SFC_PIN_OFS, 32'hc0);
      rc(`SFC_STAT_OFS, 32'h20);
      w(`SFC_PIN_OFS, 8'h07);
      rc(`SFC_PIN_OFS, 32'hc7);
      apb(1'b0, 8'h1c, 8'h00);
      check({31'h0, err}, 32'h1);
   endtask
   // Clock pin driven only for internal clock output codes
   task automatic t_clk();
      logic [2:0] c [5] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b110};
      foreach (c[i]) begin
         w(`SFC_FMT_OFS, {c[i][2], 7'h00});
         w(`SFC_CTRL_OFS, {6'h00, c[i][1:0]});
         check({31'h0, sck_oe},
               {31'h0, c[i] == 3'b001 || c[i] == 3'b100});
      end
      w(`SFC_FMT_OFS, 8'h00);
   endtask
   // Inverted transmit pin, then external tick clock
   task automatic t_tx();
      w(`SFC_PIN_OFS, 8'h02);
      @(posedge mclk);
      check({31'h0, tx1}, 32'h0);
      w(`SFC_CTRL_OFS, 8'h20);
      w(`SFC_TXD_OFS, 8'ha5);
      u_rem.grab(1'b1, got);
      check({24'h0, got}, 32'ha5);
      repeat (40) @(posedge mclk);
      w(`SFC_CTRL_OFS, 8'h22);
      w(`SFC_TXD_OFS, 8'h5a);
      repeat (40) @(posedge mclk);
      check({31'h0, tx1}, 32'h0);
      u_rem.ext16(16);
      repeat (5) @(posedge mclk);
      check({31'h0, tx1}, 32'h1);
   endtask
   // Receive on both channels, 7-bit format, framing error
   task automatic t_rx();
      w(`SFC_PIN_OFS, 8'h01);
      w(`SFC_CTRL_OFS, 8'h10);
      u_rem.send(1'b0, 1'b1, 8'h3c, 1'b1);
      apb(1'b0, `SFC_STAT_OFS, 8'h00);
      check(q & 32'h1f, 32'h01);
      rc(`SFC_RXD_OFS, 32'h3c);
      w(`SFC_CTRL_OFS, 8'h00);
      w(`SFC_PIN_OFS, 8'h04);
      w(`SFC_CTRL_OFS, 8'h50);
      w(`SFC_FMT_OFS, 8'h40);
      u_rem.send(1'b1, 1'b1, 8'hd5, 1'b1);
      rc(`SFC_RXD_OFS, 32'h55);
      w(`SFC_FMT_OFS, 8'h00);
      u_rem.send(1'b1, 1'b1, 8'h81, 1'b0);
      apb(1'b0, `SFC_STAT_OFS, 8'h00);
      check(q & 32'h04, 32'h04);
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      t_regs();
      t_clk();
      w(`SFC_DIV_OFS, 8'h00);
      t_tx();
      t_rx();
      print_verdict();
   end
endmodule
